// ### hbc_map.svh
// How it works
// - Enabled, not disabled, fault-free: each bridge output follows its polarity input.
// - Undervoltage tri-states both outputs, pulls the flag low, recovers by itself.
// - Short circuit or overtemperature latches outputs off and the flag low.
// - Short latch clears only on disable falling, enable rising or reset.
// - Overtemperature latch clears on disable falling or enable rising; outputs resume.
// - Enable edge clears below shutdown; disable edge only below threshold minus hysteresis.
// - Power cycling (reset) clears every latched fault and releases the flag.
// - Reaching the current limit tri-states outputs for a fixed 20 us off-time.
// - Above 160 C the current limit threshold folds back to 4.2 A.
// - Slightly above 175 C the device latches an overtemperature shutdown.
// - Disable input high tri-states both outputs; other logic keeps running.
// - Enable input low tri-states outputs at once and selects sleep.
// - Every output transition starts blanking before a short may be declared.
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH

`define HBC_CLK_PERIOD_NS 100
`define HBC_OFF_TIME_NS 20000
`define HBC_BLANK_TIME_NS 4000
`define HBC_TIMER_W 12

`define HBC_ADDR_CTRL 8'h00
`define HBC_ADDR_STATUS 8'h04
`define HBC_ADDR_LIMIT_COUNT 8'h08

`define HBC_CTRL_RESET 32'h0000_0001
`define HBC_CTRL_LIMIT_EN 0
`define HBC_CTRL_SW_DIS 1

`define HBC_ST_UV 0
`define HBC_ST_SC 1
`define HBC_ST_OT 2
`define HBC_ST_LIMIT 3
`define HBC_ST_FOLD 4
`define HBC_ST_SLEEP 5
`define HBC_ST_DRIVE 6
`define HBC_ST_FLAG_PIN 7

`define HBC_COUNT_W 16

`endif

// ### hbc_pkg.sv
package hbc_pkg;

  typedef enum logic [1:0] {
    HBC_SLEEP,
    HBC_OFF,
    HBC_RUN,
    HBC_LIMIT
  } hbc_mode_e;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
  } hbc_dphase_s;

  typedef struct packed {
    logic uv;
    logic sc;
    logic ot;
  } hbc_fault_s;

endpackage

// ### hbc_timer.sv
`timescale 1ns/100ps
`default_nettype none

// Load sets the count; busy stays high until the count reaches zero.
module hbc_timer #(
  parameter int W = 12
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [W-1:0] len_in,
  output logic busy_out
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cnt_q <= '0;
    else if (load_in)
      cnt_q <= len_in;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  assign busy_out = (cnt_q != '0);

endmodule

`default_nettype wire

// ### hbc_edge.sv
`timescale 1ns/100ps
`default_nettype none

// One-cycle pulses on rising and falling edges of each input bit.
module hbc_edge #(
  parameter int W = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] sig_in,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  logic [W-1:0] prev_q;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      prev_q <= '0;
    else
      prev_q <= sig_in;
  end

  assign rise_out = sig_in & ~prev_q;
  assign fall_out = ~sig_in & prev_q;

endmodule

`default_nettype wire

// ### hbc_bridge_ctrl.sv
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "hbc_map.svh"

module hbc_bridge_ctrl
  import hbc_pkg::*;
#(
  parameter int OFF_TIME_CYC =
    (`HBC_OFF_TIME_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS,
  parameter int BLANK_TIME_CYC =
    (`HBC_BLANK_TIME_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS,
  parameter int TIMER_W = `HBC_TIMER_W
) (
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  // Control pins from the microcontroller.
  input wire logic SLEEP_ENABLE_INPUT_IN,
  input wire logic OUTPUT_DISABLE_INPUT_IN,
  input wire logic POLARITY_INPUT_A_IN,
  input wire logic POLARITY_INPUT_B_IN,
  // Sense comparators of the power stage.
  input wire logic UNDERVOLTAGE_IN,
  input wire logic SHORT_DETECT_IN,
  input wire logic LIMIT_DETECT_IN,
  input wire logic TEMP_FOLDBACK_IN,
  input wire logic TEMP_SHUTDOWN_IN,
  input wire logic TEMP_HYST_CLEAR_IN,
  // Bridge outputs, open-drain fault flag, foldback select and sleep indication.
  output logic BRIDGE_OUTPUT_A_OUT,
  output logic BRIDGE_OUTPUT_A_OE_N_OUT,
  output logic BRIDGE_OUTPUT_B_OUT,
  output logic BRIDGE_OUTPUT_B_OE_N_OUT,
  input wire logic FAULT_FLAG_N_IN,
  output logic FAULT_FLAG_N_OUT,
  output logic FAULT_FLAG_N_OE_N_OUT,
  output logic LIMIT_FOLDBACK_OUT,
  output logic SLEEP_OUT,
  // AHB-Lite slave.
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  localparam logic [TIMER_W-1:0] OFF_LEN = TIMER_W'(OFF_TIME_CYC - 1);
  localparam logic [TIMER_W-1:0] BLANK_LEN = TIMER_W'(BLANK_TIME_CYC);
  localparam logic [`HBC_COUNT_W-1:0] COUNT_MAX = '1;

  logic en;
  logic dis;
  logic [1:0] rise;
  logic [1:0] fall;
  logic en_rise;
  logic dis_fall;

  hbc_fault_s fault_q;
  hbc_fault_s fault_d;
  hbc_mode_e mode_q;
  hbc_mode_e mode_d;

  logic drive_q;
  logic drive_d;
  logic out_a_q;
  logic out_b_q;
  logic blank_busy;
  logic blank_load;
  logic off_busy;
  logic limit_hit;
  logic short_hit;
  logic sc_clear;
  logic ot_clear;
  logic flag_low_q;
  logic flag_low_d;
  logic fold_q;
  logic sleep_q;

  logic [31:0] ctrl_q;
  logic limit_en;
  logic sw_dis;
  logic [`HBC_COUNT_W-1:0] limit_cnt_q;
  logic [31:0] status;
  logic [31:0] rdata_q;
  hbc_dphase_s dph_q;
  logic accept;
  logic wr_ctrl;
  logic wr_count;

  assign en = SLEEP_ENABLE_INPUT_IN;
  assign dis = OUTPUT_DISABLE_INPUT_IN;
  assign limit_en = ctrl_q[`HBC_CTRL_LIMIT_EN];
  assign sw_dis = ctrl_q[`HBC_CTRL_SW_DIS];

  ////////////////////////////////////////////////////////////////////////////
  // Edges of the enable and disable inputs clear latched faults.

  hbc_edge #(
    .W(2)
  ) u_edge (
    .clk_in(MCLK_IN),
    .rst_n_in(RESETN_IN),
    .sig_in({en, dis}),
    .rise_out(rise),
    .fall_out(fall)
  );

  assign en_rise = rise[1];
  assign dis_fall = fall[0];

  assign sc_clear = en_rise | dis_fall;
  // The enable edge only needs the die below shutdown, the disable edge
  // needs it below shutdown minus hysteresis.
  assign ot_clear = (en_rise & !TEMP_SHUTDOWN_IN) |
                    (dis_fall & TEMP_HYST_CLEAR_IN);

  ////////////////////////////////////////////////////////////////////////////
  // Protection detectors.

  // A short is only believed once blanking after a transition has ended.
  assign short_hit = drive_q & !blank_busy & SHORT_DETECT_IN;
  assign limit_hit = (mode_q == HBC_RUN) & drive_q & limit_en &
                     !blank_busy & LIMIT_DETECT_IN;

  // A detection in the same cycle as a clearing edge wins.
  always_comb
  begin
    fault_d.uv = UNDERVOLTAGE_IN;
    if (short_hit)
      fault_d.sc = 1'b1;
    else if (sc_clear)
      fault_d.sc = 1'b0;
    else
      fault_d.sc = fault_q.sc;
    if (TEMP_SHUTDOWN_IN)
      fault_d.ot = 1'b1;
    else if (ot_clear)
      fault_d.ot = 1'b0;
    else
      fault_d.ot = fault_q.ot;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      fault_q <= '0;
    else
      fault_q <= fault_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridge mode.

  always_comb
  begin
    mode_d = mode_q;
    if (!en)
      mode_d = HBC_SLEEP;
    else if (dis | sw_dis | fault_d.uv | fault_d.sc | fault_d.ot)
      mode_d = HBC_OFF;
    else
    begin
      case (mode_q)
        HBC_RUN:
          if (limit_hit)
            mode_d = HBC_LIMIT;
        HBC_LIMIT:
          if (!off_busy)
            mode_d = HBC_RUN;
        default:
          mode_d = HBC_RUN;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      mode_q <= HBC_SLEEP;
    else
      mode_q <= mode_d;
  end

  hbc_timer #(
    .W(TIMER_W)
  ) u_off_timer (
    .clk_in(MCLK_IN),
    .rst_n_in(RESETN_IN),
    .load_in(limit_hit),
    .len_in(OFF_LEN),
    .busy_out(off_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage and blanking.

  assign drive_d = (mode_d == HBC_RUN);

  // Any change of driven level, or the switch from off to driving, restarts blanking.
  assign blank_load = drive_d & (!drive_q |
                      (POLARITY_INPUT_A_IN != out_a_q) |
                      (POLARITY_INPUT_B_IN != out_b_q));

  hbc_timer #(
    .W(TIMER_W)
  ) u_blank_timer (
    .clk_in(MCLK_IN),
    .rst_n_in(RESETN_IN),
    .load_in(blank_load),
    .len_in(BLANK_LEN),
    .busy_out(blank_busy)
  );

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      drive_q <= 1'b0;
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end
    else
    begin
      drive_q <= drive_d;
      out_a_q <= POLARITY_INPUT_A_IN;
      out_b_q <= POLARITY_INPUT_B_IN;
    end
  end

  assign BRIDGE_OUTPUT_A_OUT = out_a_q;
  assign BRIDGE_OUTPUT_B_OUT = out_b_q;
  assign BRIDGE_OUTPUT_A_OE_N_OUT = !drive_q;
  assign BRIDGE_OUTPUT_B_OE_N_OUT = !drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fault flag, foldback select and sleep indication.

  // Sleep overrides every other source and keeps the flag released.
  assign flag_low_d = en & (dis | fault_d.uv | fault_d.sc |
                            fault_d.ot);

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      flag_low_q <= 1'b0;
    else
      flag_low_q <= flag_low_d;
  end

  assign FAULT_FLAG_N_OUT = 1'b0;
  assign FAULT_FLAG_N_OE_N_OUT = !flag_low_q;

  // The analog limit comparator takes the folded threshold when high.
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      fold_q <= 1'b0;
      sleep_q <= 1'b1;
    end
    else
    begin
      fold_q <= TEMP_FOLDBACK_IN;
      sleep_q <= !en;
    end
  end

  assign LIMIT_FOLDBACK_OUT = fold_q;
  assign SLEEP_OUT = sleep_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file over AHB-Lite, zero wait states, always OKAY.

  assign accept = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  assign wr_ctrl = dph_q.valid & dph_q.wr &
                   hit(dph_q.addr, `HBC_ADDR_CTRL);
  assign wr_count = dph_q.valid & dph_q.wr &
                    hit(dph_q.addr, `HBC_ADDR_LIMIT_COUNT);

  always_comb
  begin
    status = '0;
    status[`HBC_ST_UV] = fault_q.uv;
    status[`HBC_ST_SC] = fault_q.sc;
    status[`HBC_ST_OT] = fault_q.ot;
    status[`HBC_ST_LIMIT] = (mode_q == HBC_LIMIT);
    status[`HBC_ST_FOLD] = fold_q;
    status[`HBC_ST_SLEEP] = sleep_q;
    status[`HBC_ST_DRIVE] = drive_q;
    status[`HBC_ST_FLAG_PIN] = FAULT_FLAG_N_IN;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      dph_q <= '0;
    else
    begin
      dph_q.valid <= accept;
      dph_q.wr <= HWRITE_IN;
      dph_q.addr <= HADDR_IN[7:0];
    end
  end

  // Read data are sampled at the end of the address phase.
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      rdata_q <= '0;
    else if (accept & !HWRITE_IN)
    begin
      if (hit(HADDR_IN[7:0], `HBC_ADDR_CTRL))
        rdata_q <= ctrl_q;
      else if (hit(HADDR_IN[7:0], `HBC_ADDR_STATUS))
        rdata_q <= status;
      else if (hit(HADDR_IN[7:0], `HBC_ADDR_LIMIT_COUNT))
        rdata_q <= {{(32 - `HBC_COUNT_W){1'b0}}, limit_cnt_q};
      else
        rdata_q <= '0;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      ctrl_q <= `HBC_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= {30'h0, HWDATA_IN[1:0]};
  end

  // Saturating count of off-time events; a clear in the same cycle as a new event leaves the count at 1.
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      limit_cnt_q <= '0;
    else if (limit_hit)
    begin
      if (wr_count)
        limit_cnt_q <= `HBC_COUNT_W'(1);
      else if (limit_cnt_q != COUNT_MAX)
        limit_cnt_q <= limit_cnt_q + `HBC_COUNT_W'(1);
    end
    else if (wr_count)
      limit_cnt_q <= '0;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT <= 1'b0;
    end
    else
    begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  assign HRDATA_OUT = rdata_q;

endmodule

`default_nettype wire

// ### hbc_bridge_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module hbc_bridge_ctrl_chk (
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic SLEEP_ENABLE_INPUT_IN,
  input wire logic OUTPUT_DISABLE_INPUT_IN,
  input wire logic UNDERVOLTAGE_IN,
  input wire logic TEMP_FOLDBACK_IN,
  input wire logic TEMP_SHUTDOWN_IN,
  input wire logic TEMP_HYST_CLEAR_IN,
  input wire logic BRIDGE_OUTPUT_A_OE_N_OUT,
  input wire logic BRIDGE_OUTPUT_B_OE_N_OUT,
  input wire logic FAULT_FLAG_N_OE_N_OUT,
  input wire logic LIMIT_FOLDBACK_OUT
);
  wire logic en = SLEEP_ENABLE_INPUT_IN;
  wire logic dis = OUTPUT_DISABLE_INPUT_IN;
  wire logic off = BRIDGE_OUTPUT_A_OE_N_OUT & BRIDGE_OUTPUT_B_OE_N_OUT;
  wire logic rel = FAULT_FLAG_N_OE_N_OUT;
  wire logic calm = !UNDERVOLTAGE_IN & !TEMP_SHUTDOWN_IN;
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  sequence s_ot_trip;
    en && TEMP_SHUTDOWN_IN;
  endsequence
  sequence s_no_clear;
    en && !$fell(dis);
  endsequence
  a_disable_off: assert property (en && dis |=> off && !rel)
    else $error("disable not applied");
  a_sleep_off: assert property (!en |=> off && rel)
    else $error("sleep not applied");
  a_uv_off: assert property (en && UNDERVOLTAGE_IN |=> off && !rel)
    else $error("undervoltage not applied");
  a_ot_trip: assert property (s_ot_trip |=> off && !rel)
    else $error("overtemperature not applied");
  a_ot_latched: assert property (
    s_ot_trip ##1 s_no_clear [*3] |=> off && !rel)
    else $error("overtemperature latch lost");
  a_fold_rise: assert property (
    $rose(TEMP_FOLDBACK_IN) |=> LIMIT_FOLDBACK_OUT)
    else $error("foldback not selected");
  a_dis_clear: assert property (
    $fell(dis) && en && calm && TEMP_HYST_CLEAR_IN |=> rel)
    else $error("disable edge did not clear");
  a_en_clear: assert property ($rose(en) && !dis && calm |=> rel)
    else $error("enable edge did not clear");
endmodule
bind hbc_bridge_ctrl hbc_bridge_ctrl_chk chk_u (.MCLK_IN, .RESETN_IN,
  .SLEEP_ENABLE_INPUT_IN, .OUTPUT_DISABLE_INPUT_IN, .UNDERVOLTAGE_IN,
  .TEMP_FOLDBACK_IN, .TEMP_SHUTDOWN_IN, .TEMP_HYST_CLEAR_IN,
  .BRIDGE_OUTPUT_A_OE_N_OUT, .BRIDGE_OUTPUT_B_OE_N_OUT,
  .FAULT_FLAG_N_OE_N_OUT, .LIMIT_FOLDBACK_OUT);
`default_nettype wire

// ### hbc_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
module hbc_mcu_model (
  input wire logic clk_in,
  input wire logic flag_oe_n_in,
  output logic en_out,
  output logic dis_out,
  output logic pa_out,
  output logic pb_out,
  output logic flag_out
);
  // The flag wire has a pull-up, so a released flag reads high.
  assign flag_out = flag_oe_n_in ? 1'b1 : 1'b0;
  initial {en_out, dis_out, pa_out, pb_out} = 4'h0;
  // Edges of enable and disable are what clear a latched fault.
  task automatic drive(input logic [3:0] v);
    @(posedge clk_in);
    {en_out, dis_out, pa_out, pb_out} <= v;
  endtask
endmodule
`default_nettype wire

// ### hbc_bridge_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module hbc_bridge_ctrl_tb;
  localparam int OFF = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] sn = 6'h01;
  logic [1:0] htr = 2'h0;
  logic [31:0] hadr = 32'h0;
  logic hw = 1'b0;
  logic [31:0] hwd = 32'h0;
  logic en, dis, pa, pb, oa, a, ob, b, fo, fl, fold, hrdy;
  logic [31:0] hrd;
  logic slp, ffo, hrsp;
  logic [31:0] r;
  int n;
  int mismatches = 0;
  int n_compared = 0;
  wire logic [31:0] obs = {27'h0, oa, a, ob, b, fo};
  // Each row: enable, disable, polarity A, B, then OE_N A, A, OE_N B, B, flag.
  logic [8:0] rows [7] = '{9'h149, 9'h123, 9'h101, 9'h16b, 9'h1dc,
    9'h07f, 9'h149};

  always #50 clk = ~clk;

  hbc_mcu_model mcu_u (.clk_in(clk), .flag_oe_n_in(fo), .en_out(en),
    .dis_out(dis), .pa_out(pa), .pb_out(pb), .flag_out(fl));

  hbc_bridge_ctrl #(.OFF_TIME_CYC(OFF), .BLANK_TIME_CYC(3)) dut_u (
    .MCLK_IN(clk), .RESETN_IN(rst_n), .SLEEP_ENABLE_INPUT_IN(en),
    .OUTPUT_DISABLE_INPUT_IN(dis), .POLARITY_INPUT_A_IN(pa),
    .POLARITY_INPUT_B_IN(pb), .UNDERVOLTAGE_IN(sn[5]),
    .SHORT_DETECT_IN(sn[4]), .LIMIT_DETECT_IN(sn[3]),
    .TEMP_FOLDBACK_IN(sn[2]), .TEMP_SHUTDOWN_IN(sn[1]),
    .TEMP_HYST_CLEAR_IN(sn[0]), .BRIDGE_OUTPUT_A_OUT(a),
    .BRIDGE_OUTPUT_A_OE_N_OUT(oa), .BRIDGE_OUTPUT_B_OUT(b),
    .BRIDGE_OUTPUT_B_OE_N_OUT(ob), .FAULT_FLAG_N_IN(fl),
    .FAULT_FLAG_N_OUT(ffo), .FAULT_FLAG_N_OE_N_OUT(fo),
    .LIMIT_FOLDBACK_OUT(fold), .SLEEP_OUT(slp), .HSEL_IN(1'b1),
    .HADDR_IN(hadr), .HTRANS_IN(htr), .HWRITE_IN(hw), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwd), .HREADY_IN(hrdy), .HRDATA_OUT(hrd),
    .HREADYOUT_OUT(hrdy), .HRESP_OUT(hrsp));

  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Control pins and sense inputs change on one edge, then w edges pass.
  task automatic step(input logic [3:0] c, input logic [5:0] v, input int w);
    mcu_u.drive(c);
    sn <= v;
    repeat (w) @(posedge clk);
    #1;
  endtask

  task automatic count_off(output int k);
    k = 0;
    repeat (12)
    begin
      if (oa === 1'b1)
        k++;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] ad, wd,
    output logic [31:0] rd);
    @(posedge clk);
    htr <= 2'h2;
    hadr <= ad;
    hw <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htr <= 2'h0;
    hwd <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrd;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    stop_test;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      step(rows[i][8:5], 6'h01, 4);
      chk(obs, {27'h0, rows[i][4:0]});
    end
    $display("end truth table");
    step(4'ha, 6'h01, 3);
    step(4'ha, 6'h09, 0);
    step(4'ha, 6'h01, 0);
    count_off(n);
    chk(32'(n), 32'(OFF));
    chk(obs, 32'h9);
    bus(1'b0, 32'h8, 32'h0, r);
    chk(r, 32'h1);
    bus(1'b1, 32'h8, 32'h0, r);
    bus(1'b0, 32'h8, 32'h0, r);
    chk(r, 32'h0);
    step(4'h9, 6'h01, 1);
    step(4'h9, 6'h09, 0);
    step(4'h9, 6'h01, 0);
    count_off(n);
    chk(32'(n), 32'h0);
    $display("end current limit");
    step(4'h9, 6'h21, 2);
    chk(obs, 32'h16);
    step(4'h9, 6'h01, 4);
    chk(obs, 32'h3);
    $display("end undervoltage");
    step(4'h9, 6'h11, 0);
    step(4'h9, 6'h01, 3);
    chk(obs, 32'h16);
    step(4'hd, 6'h01, 0);
    step(4'h9, 6'h01, 4);
    chk(obs, 32'h3);
    $display("end short circuit");
    step(4'h9, 6'h02, 0);
    step(4'h9, 6'h00, 3);
    chk(obs, 32'h16);
    step(4'hd, 6'h00, 0);
    step(4'h9, 6'h00, 3);
    chk(obs, 32'h16);
    step(4'h1, 6'h00, 1);
    step(4'h9, 6'h01, 4);
    chk(obs, 32'h3);
    $display("end overtemperature");
    // The hot spell is kept short, as the system side must.
    step(4'h9, 6'h05, 2);
    chk({31'h0, fold}, 32'h1);
    step(4'h9, 6'h01, 0);
    $display("end foldback");
    // Latch a short, then sleep, so that only the reset can clear it.
    step(4'h9, 6'h11, 0);
    step(4'h1, 6'h01, 0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 32'h4, 32'h0, r);
    chk(r, 32'ha0);
    chk({29'h0, slp, ffo, hrsp}, 32'h4);
    step(4'h9, 6'h01, 6);
    chk(obs, 32'h3);
    bus(1'b0, 32'h0, 32'h0, r);
    chk(r, 32'h1);
    bus(1'b0, 32'h10, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b1, 32'h0, 32'h3, r);
    step(4'h9, 6'h01, 1);
    chk(obs, 32'h17);
    bus(1'b0, 32'h0, 32'h0, r);
    chk(r, 32'h3);
    $display("end reset and registers");
    stop_test;
  end
endmodule
`default_nettype wire
